// ===== rtl/pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module pin_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RESET_VALUE = '0
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic [W-1:0] pins,
    output logic [W-1:0] level
);
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
    logic [W-1:0] stage3;

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge clock or negedge rstn) begin
                if (!rstn) begin
                    stage1[i] <= RESET_VALUE[i];
                    stage2[i] <= RESET_VALUE[i];
                    stage3[i] <= RESET_VALUE[i];
                    level[i] <= RESET_VALUE[i];
                end else begin
                    stage1[i] <= pins[i];
                    stage2[i] <= stage1[i];
                    stage3[i] <= stage2[i];
                    // A change counts only when two stages agree
                    if (stage2[i] == stage3[i]) begin
                        level[i] <= stage3[i];
                    end
                end
            end
        end
    endgenerate
endmodule // pin_sync

// ===== rtl/power_on_if.sv
// Interface between the configuration registers and the power-on timer
`timescale 1ns/100ps
interface power_on_if;
    logic xosc_stable;
    logic [1:0] wait_select;
    logic chip_ready_low;

    modport timer (input xosc_stable, input wait_select, output chip_ready_low);
    modport ctrl (output xosc_stable, output wait_select, input chip_ready_low);
endinterface

// ===== rtl/power_on_timer.sv
// Ripple-counter wait between oscillator start and chip-ready
`timescale 1ns/100ps
module power_on_timer
    import radio_cfg_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    power_on_if.timer port
);
    logic [RIPPLE_W-1:0] ripple;
    logic [8:0] expirations;

    wire expire = (ripple == RIPPLE_TOP);
    wire [8:0] target = (port.wait_select == 2'h0) ? EXPIRE_COUNT_0 :
                        (port.wait_select == 2'h1) ? EXPIRE_COUNT_1 :
                        (port.wait_select == 2'h2) ? EXPIRE_COUNT_2 : EXPIRE_COUNT_3; // R13
    wire [8:0] next_expirations = expirations + 9'h001;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ripple <= '0;
            expirations <= '0;
            port.chip_ready_low <= 1'b1;
        end else if (!port.xosc_stable) begin
            ripple <= '0;
            expirations <= '0;
            port.chip_ready_low <= 1'b1;
        end else if (port.chip_ready_low) begin
            ripple <= ripple + 6'h01;
            if (expire) begin
                expirations <= next_expirations;
                if (next_expirations == target) begin
                    port.chip_ready_low <= 1'b0; // R12
                end
            end
        end
    end
endmodule // power_on_timer

// ===== rtl/radio_cfg_pkg.sv
// Constants and types for the radio state policy configuration block
package radio_cfg_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam int ADDR_W = 6;
    localparam int DATA_W = 8;
    localparam logic [5:0] RADIO_NEXT_STATE_CONFIG_ADDR = 6'h17;
    localparam logic [5:0] RADIO_CALIBRATION_CONFIG_ADDR = 6'h18;
    localparam logic [5:0] CALIBRATE_STROBE_ADDR = 6'h33;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // ****************************************
    // Field positions and reset values
    // ****************************************
    localparam int CLEAR_CHANNEL_SELECT_LSB = 4;
    localparam int AFTER_RECEIVE_STATE_LSB = 2;
    localparam int AFTER_TRANSMIT_STATE_LSB = 0;
    localparam int SYNTH_AUTO_CALIBRATION_LSB = 4;
    localparam int POWER_ON_WAIT_SELECT_LSB = 2;
    localparam logic [1:0] CLEAR_CHANNEL_SELECT_RST = 2'h3;
    localparam logic [1:0] AFTER_RECEIVE_STATE_RST = 2'h0;
    localparam logic [1:0] AFTER_TRANSMIT_STATE_RST = 2'h0;
    localparam logic [1:0] SYNTH_AUTO_CALIBRATION_RST = 2'h0;
    localparam logic [1:0] POWER_ON_WAIT_SELECT_RST = 2'h1;

    // ****************************************
    // Serial header layout
    // ****************************************
    localparam int HEADER_READ_BIT = 7;
    localparam int HEADER_BURST_BIT = 6;
    localparam logic [2:0] LAST_BIT_INDEX = 3'h7;

    // ****************************************
    // Timing counts
    // ****************************************
    localparam int RIPPLE_W = 6;
    localparam logic [RIPPLE_W-1:0] RIPPLE_TOP = 6'h3f;
    localparam logic [8:0] EXPIRE_COUNT_0 = 9'h001;
    localparam logic [8:0] EXPIRE_COUNT_1 = 9'h010;
    localparam logic [8:0] EXPIRE_COUNT_2 = 9'h040;
    localparam logic [8:0] EXPIRE_COUNT_3 = 9'h100;
    localparam logic [1:0] CAL_RETURN_LAST = 2'h3;

    // ****************************************
    // Modes
    // ****************************************
    typedef enum logic [1:0] {
        CCA_ALWAYS = 2'b00,
        CCA_BELOW_THRESHOLD = 2'b01,
        CCA_NOT_RECEIVING = 2'b10,
        CCA_BOTH = 2'b11
    } clear_channel_mode_e;

    typedef enum logic [1:0] {
        AFTER_RX_IDLE = 2'b00,
        AFTER_RX_SYNTH_ON = 2'b01,
        AFTER_RX_TRANSMIT = 2'b10,
        AFTER_RX_RECEIVE = 2'b11
    } after_receive_e;

    typedef enum logic [1:0] {
        AFTER_TX_IDLE = 2'b00,
        AFTER_TX_SYNTH_ON = 2'b01,
        AFTER_TX_TRANSMIT = 2'b10,
        AFTER_TX_RECEIVE = 2'b11
    } after_transmit_e;

    typedef enum logic [1:0] {
        AUTOCAL_NEVER = 2'b00,
        AUTOCAL_LEAVE_IDLE = 2'b01,
        AUTOCAL_RETURN_IDLE = 2'b10,
        AUTOCAL_EVERY_FOURTH = 2'b11
    } autocal_e;

    typedef enum logic {
        PHASE_HEADER = 1'b0,
        PHASE_DATA = 1'b1
    } serial_phase_e;

endpackage

// ===== rtl/radio_state_policy_config.sv
// Radio state policy configuration registers with serial register port
`timescale 1ns/100ps
// Summary of operation
// R1: A 2-bit clear-channel select, reset 3, picks always, low signal, not receiving, or both.
// R2: The clear-channel output follows the result of the selected mode.
// R3: A 2-bit after-receive field, reset 0, picks idle, synth on, transmit or stay in receive.
// R4: The host never pairs an after-receive of transmit or synth on with clear-channel use.
// R5: A 2-bit after-transmit field, reset 0, picks idle, synth on, stay in transmit or receive.
// R6: After-transmit code 2 keeps transmit and restarts preamble at once after a packet.
// R7: Auto-calibration code 0, the reset value, calibrates only on the calibrate strobe.
// R8: Code 1 calibrates on every exit from idle to receive, transmit or synth on.
// R9: Code 2 calibrates on every automatic return from receive or transmit to idle.
// R10: Code 3 calibrates on every fourth such return, counted.
// R11: For wake-on-radio the host should pick auto-calibration code 3.
// R12: After the oscillator settles, chip-ready goes low after the selected ripple expirations.
// R13: Power-on wait select 0, 1, 2, 3 gives 1, 16, 64, 256 expirations, reset 1.
// R14: The every-fourth counter counts only automatic returns and restarts on its calibration.
module radio_state_policy_config
    import radio_cfg_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic spi_clock,
    input wire logic spi_select_low,
    input wire logic spi_data_in,
    output logic spi_data_out,
    output logic spi_data_out_oe,
    input wire logic signal_below_threshold,
    input wire logic receiving_packet,
    input wire logic transmit_done,
    input wire logic leave_idle,
    input wire logic auto_return_idle,
    input wire logic xosc_stable,
    output logic clear_channel_assessment,
    output radio_cfg_pkg::after_receive_e after_receive_state,
    output radio_cfg_pkg::after_transmit_e after_transmit_state,
    output logic restart_preamble,
    output logic calibrate_request,
    output logic chip_ready_low
);
    import radio_cfg_pkg::*;

    // ****************************************
    // Pin synchronisation
    // ****************************************
    logic sclk_level;
    logic select_low_level;
    logic mosi_level;

    pin_sync #(
        .W(3),
        .RESET_VALUE(3'b010)
    ) u_pin_sync (
        .clock(clock),
        .rstn(rstn),
        .pins({spi_clock, spi_select_low, spi_data_in}),
        .level({sclk_level, select_low_level, mosi_level})
    );

    logic sclk_prev;
    logic selected_prev;

    wire selected = !select_low_level;
    wire sclk_rise = selected && sclk_level && !sclk_prev;
    wire sclk_fall = selected && !sclk_level && sclk_prev;
    wire select_start = selected && !selected_prev;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            sclk_prev <= 1'b0;
            selected_prev <= 1'b0;
        end else begin
            sclk_prev <= sclk_level;
            selected_prev <= selected;
        end
    end

    // ****************************************
    // Serial frame decode
    // ****************************************
    serial_phase_e phase;
    logic [2:0] bit_index;
    logic [7:0] shift_in;
    logic [7:0] shift_out;
    logic [ADDR_W-1:0] address;
    logic access_read;
    logic access_burst;

    wire byte_done = sclk_rise && (bit_index == LAST_BIT_INDEX);
    wire [7:0] byte_value = {shift_in[6:0], mosi_level};
    wire header_done = byte_done && (phase == PHASE_HEADER);
    wire data_done = byte_done && (phase == PHASE_DATA);
    wire [ADDR_W-1:0] next_address = address + 6'h01;
    wire [ADDR_W-1:0] lookup_address = header_done ? byte_value[ADDR_W-1:0] : next_address;
    wire header_write = !byte_value[HEADER_READ_BIT];
    // Strobe address carries no data byte
    wire strobe_hit = header_done && header_write && (byte_value[ADDR_W-1:0] == CALIBRATE_STROBE_ADDR);
    wire reg_write = data_done && !access_read;
    // Next-byte data is fetched at byte end, before the following bit leaves
    wire [7:0] status_byte = {chip_ready_low, 7'h00};

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            phase <= PHASE_HEADER;
            bit_index <= '0;
            shift_in <= '0;
            address <= '0;
            access_read <= 1'b0;
            access_burst <= 1'b0;
        end else if (!selected) begin
            phase <= PHASE_HEADER;
            bit_index <= '0;
        end else if (sclk_rise) begin
            shift_in <= byte_value;
            bit_index <= bit_index + 3'h1;
            case (phase)
                PHASE_HEADER: begin
                    if (byte_done && !strobe_hit) begin
                        phase <= PHASE_DATA;
                        address <= byte_value[ADDR_W-1:0];
                        access_read <= byte_value[HEADER_READ_BIT];
                        access_burst <= byte_value[HEADER_BURST_BIT];
                    end
                end
                PHASE_DATA: begin
                    if (byte_done) begin
                        if (access_burst) begin
                            address <= next_address;
                        end else begin
                            phase <= PHASE_HEADER;
                        end
                    end
                end
                default: begin
                    phase <= PHASE_HEADER;
                end
            endcase
        end
    end

    // ****************************************
    // Configuration registers
    // ****************************************
    logic [1:0] clear_channel_select;
    logic [1:0] after_receive_field;
    logic [1:0] after_transmit_field;
    logic [1:0] synth_auto_calibration;
    logic [1:0] power_on_wait_select;

    wire write_next_state = reg_write && (address == RADIO_NEXT_STATE_CONFIG_ADDR);
    wire write_calibration = reg_write && (address == RADIO_CALIBRATION_CONFIG_ADDR);
    wire [7:0] next_state_word = {2'b00, clear_channel_select, after_receive_field, after_transmit_field};
    wire [7:0] calibration_word = {2'b00, synth_auto_calibration, power_on_wait_select, 2'b00};
    logic [7:0] read_word;

    always_comb begin
        if (lookup_address == RADIO_NEXT_STATE_CONFIG_ADDR) begin
            read_word = next_state_word;
        end else if (lookup_address == RADIO_CALIBRATION_CONFIG_ADDR) begin
            read_word = calibration_word;
        end else begin
            read_word = UNMAPPED_READ;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            clear_channel_select <= CLEAR_CHANNEL_SELECT_RST; // R1
            after_receive_field <= AFTER_RECEIVE_STATE_RST; // R3
            after_transmit_field <= AFTER_TRANSMIT_STATE_RST; // R5
            synth_auto_calibration <= SYNTH_AUTO_CALIBRATION_RST; // R7
            power_on_wait_select <= POWER_ON_WAIT_SELECT_RST; // R13
        end else begin
            if (write_next_state) begin
                clear_channel_select <= byte_value[CLEAR_CHANNEL_SELECT_LSB+:2]; // R1
                after_receive_field <= byte_value[AFTER_RECEIVE_STATE_LSB+:2]; // R3
                after_transmit_field <= byte_value[AFTER_TRANSMIT_STATE_LSB+:2]; // R5
            end
            if (write_calibration) begin
                synth_auto_calibration <= byte_value[SYNTH_AUTO_CALIBRATION_LSB+:2];
                power_on_wait_select <= byte_value[POWER_ON_WAIT_SELECT_LSB+:2]; // R13
            end
        end
    end

    // ****************************************
    // Serial output
    // ****************************************
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            shift_out <= '0;
            spi_data_out <= 1'b0;
            spi_data_out_oe <= 1'b0;
        end else begin
            spi_data_out_oe <= selected;
            if (select_start) begin
                spi_data_out <= status_byte[7];
                shift_out <= {status_byte[6:0], 1'b0};
            end else if (byte_done) begin
                shift_out <= read_word;
            end else if (sclk_fall) begin
                spi_data_out <= shift_out[7];
                shift_out <= {shift_out[6:0], 1'b0};
            end
        end
    end

    // ****************************************
    // Radio policy
    // ****************************************
    logic [1:0] return_count;
    logic next_clear;

    always_comb begin
        case (clear_channel_mode_e'(clear_channel_select))
            CCA_ALWAYS: next_clear = 1'b1; // R1
            CCA_BELOW_THRESHOLD: next_clear = signal_below_threshold;
            CCA_NOT_RECEIVING: next_clear = !receiving_packet;
            CCA_BOTH: next_clear = signal_below_threshold && !receiving_packet;
            default: next_clear = 1'b1;
        endcase
    end

    wire mode_every_fourth = (synth_auto_calibration == AUTOCAL_EVERY_FOURTH);
    wire fourth_return = mode_every_fourth && auto_return_idle && (return_count == CAL_RETURN_LAST);
    wire auto_cal_hit = ((synth_auto_calibration == AUTOCAL_LEAVE_IDLE) && leave_idle) || // R8
                        ((synth_auto_calibration == AUTOCAL_RETURN_IDLE) && auto_return_idle) || // R9
                        fourth_return; // R10
    wire restart_hit = transmit_done && (after_transmit_field == AFTER_TX_TRANSMIT);

    // The after-receive choice is passed on as written; the host keeps it apart from channel checks
    assign after_receive_state = after_receive_e'(after_receive_field); // R3 R4
    assign after_transmit_state = after_transmit_e'(after_transmit_field); // R5

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            clear_channel_assessment <= 1'b1;
            restart_preamble <= 1'b0;
            calibrate_request <= 1'b0;
            return_count <= '0;
        end else begin
            clear_channel_assessment <= next_clear; // R2
            restart_preamble <= restart_hit; // R6
            calibrate_request <= strobe_hit || auto_cal_hit; // R7
            if (!mode_every_fourth || fourth_return) begin
                return_count <= '0; // R14
            end else if (auto_return_idle) begin
                return_count <= return_count + 2'h1; // R14
            end
        end
    end

    // ****************************************
    // Power-on wait
    // ****************************************
    power_on_if power_on ();

    assign power_on.xosc_stable = xosc_stable;
    assign power_on.wait_select = power_on_wait_select;
    assign chip_ready_low = power_on.chip_ready_low; // R12

    power_on_timer u_power_on_timer (
        .clock(clock),
        .rstn(rstn),
        .port(power_on.timer)
    );
endmodule // radio_state_policy_config

// ===== tb/radio_state_policy_config_checker.sv
// Port-level assertions for the radio state policy configuration block
`timescale 1ns/100ps
module radio_state_policy_config_checker
    import radio_cfg_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic spi_select_low,
    input wire logic spi_data_out_oe,
    input wire logic signal_below_threshold,
    input wire logic receiving_packet,
    input wire logic transmit_done,
    input wire logic leave_idle,
    input wire logic auto_return_idle,
    input wire logic xosc_stable,
    input wire logic clear_channel_assessment,
    input wire radio_cfg_pkg::after_receive_e after_receive_state,
    input wire radio_cfg_pkg::after_transmit_e after_transmit_state,
    input wire logic restart_preamble,
    input wire logic calibrate_request,
    input wire logic chip_ready_low
);
    import radio_cfg_pkg::*;
    // ****
    // Helper counters
    // ****
    logic [5:0] sel_age;
    logic [9:0] stable_run;
    logic [5:0] next_sel_age;
    logic [9:0] next_stable_run;
    // Window stays open while selected and for 32 clocks after select rises
    assign next_sel_age = !spi_select_low ? 6'h20 : (sel_age == 6'h00 ? 6'h00 : sel_age - 6'h01);
    assign next_stable_run = !xosc_stable ? 10'h000 : (stable_run == 10'h3ff ? stable_run : stable_run + 10'h001);
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            sel_age <= 6'h00;
            stable_run <= 10'h000;
        end else begin
            sel_age <= next_sel_age;
            stable_run <= next_stable_run;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    a_cca_clear_input: assert property (
        $past(signal_below_threshold && !receiving_packet) |-> clear_channel_assessment)
        else $error("clear channel low with weak signal and no packet");
    a_restart_cause: assert property (
        restart_preamble |-> $past(transmit_done) && $past(after_transmit_state) == AFTER_TX_TRANSMIT)
        else $error("preamble restart without cause");
    a_restart_follow: assert property (
        transmit_done && after_transmit_state == AFTER_TX_TRANSMIT |=> restart_preamble)
        else $error("preamble restart missing");
    a_restart_single: assert property (
        restart_preamble |=> !restart_preamble)
        else $error("preamble restart longer than one cycle");
    a_cal_has_cause: assert property (
        calibrate_request |-> $past(leave_idle || auto_return_idle) || sel_age != 6'h00)
        else $error("calibration request without cause");
    a_state_write_only: assert property (
        $changed(after_receive_state) || $changed(after_transmit_state) |-> sel_age != 6'h00)
        else $error("next state changed without a write");
    a_ready_drop: assert property (
        !xosc_stable [*3] |-> chip_ready_low)
        else $error("chip ready while oscillator unstable");
    a_ready_wait: assert property (
        $fell(chip_ready_low) |-> stable_run >= 10'h03e)
        else $error("chip ready before one counter expiry");
    a_oe_idle: assert property (
        spi_select_low [*8] |-> !spi_data_out_oe)
        else $error("data output enabled while deselected");
endmodule // radio_state_policy_config_checker

bind radio_state_policy_config radio_state_policy_config_checker checker_inst (.*);

// ===== tb/spi_host.sv
// Host controller model driving the serial register port
`timescale 1ns/100ps
module spi_host (
    input wire logic clock,
    output logic spi_clock,
    output logic spi_select_low,
    output logic spi_data_in,
    input wire logic spi_data_out
);
    initial begin
        spi_clock = 1'b0;
        spi_select_low = 1'b1;
        spi_data_in = 1'b0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(negedge clock);
    endtask

    task automatic open_frame();
        wait_clk(1);
        spi_select_low = 1'b0;
        wait_clk(8);
    endtask

    // Half period of 8 clocks clears the pin filter delay
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            spi_data_in = tx[i];
            wait_clk(8);
            spi_clock = 1'b1;
            rx[i] = spi_data_out;
            wait_clk(8);
            spi_clock = 1'b0;
        end
    endtask

    // Released data line shows the inverse, never a stale bit
    task automatic close_frame();
        wait_clk(8);
        spi_select_low = 1'b1;
        spi_data_in = ~spi_data_in;
        wait_clk(12);
    endtask
endmodule // spi_host

// ===== tb/tb_radio_state_policy_config.sv
// Self-checking bench for the radio state policy configuration block
`timescale 1ns/100ps
module tb_radio_state_policy_config;
    import radio_cfg_pkg::*;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic signal_below_threshold = 1'b0;
    logic receiving_packet = 1'b0;
    logic transmit_done = 1'b0;
    logic leave_idle = 1'b0;
    logic auto_return_idle = 1'b0;
    logic xosc_stable = 1'b1;
    logic spi_clock, spi_select_low, spi_data_in, spi_data_out, spi_data_out_oe;
    logic clear_channel_assessment, restart_preamble, calibrate_request, chip_ready_low, exp;
    after_receive_e after_receive_state;
    after_transmit_e after_transmit_state;
    logic [7:0] rx;
    int fail_count = 0;
    int total_checks = 0;
    int cycles = 0;
    int restart_seen = 0;
    int cal_seen = 0;
    int exp_n, wait_n;

    always #5 clock = ~clock;

    radio_state_policy_config uut (.*);

    spi_host host (.clock(clock), .spi_clock(spi_clock), .spi_select_low(spi_select_low),
        .spi_data_in(spi_data_in), .spi_data_out(spi_data_out));

    // ****
    // Tasks
    // ****
    task automatic end_sim();
        $display("checks %0d, mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic check_val(input string what, input logic [7:0] want, input logic [7:0] got);
        total_checks++;
        if (got !== want) begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", what, want, got);
        end
    endtask

    task automatic check_count(input string what, input int lo, input int hi, input int got);
        total_checks++;
        if (got < lo || got > hi) begin
            fail_count++;
            $display("unexpected %s: expected %0d..%0d, seen %0d", what, lo, hi, got);
        end
    endtask

    task automatic reg_write(input logic [5:0] addr, input logic [7:0] data);
        logic [7:0] junk;
        host.open_frame();
        host.xfer({2'b00, addr}, junk);
        host.xfer(data, junk);
        host.close_frame();
    endtask

    task automatic reg_read(input logic [5:0] addr, output logic [7:0] data);
        logic [7:0] junk;
        host.open_frame();
        host.xfer({2'b10, addr}, junk);
        host.xfer(8'h00, data);
        host.close_frame();
    endtask

    task automatic strobe();
        logic [7:0] junk;
        host.open_frame();
        host.xfer({2'b00, CALIBRATE_STROBE_ADDR}, junk);
        host.close_frame();
    endtask

    // Pulses stay apart so no two causes share a cycle
    task automatic pulse(input int which);
        @(negedge clock);
        {auto_return_idle, leave_idle, transmit_done} = 3'b001 << which;
        @(negedge clock);
        {auto_return_idle, leave_idle, transmit_done} = 3'b000;
        repeat (4) @(negedge clock);
    endtask

    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (restart_preamble === 1'b1) restart_seen <= restart_seen + 1;
        if (calibrate_request === 1'b1) cal_seen <= cal_seen + 1;
        if (cycles == 60000) begin
            $display("timeout after %0d cycles", cycles);
            fail_count++;
            end_sim();
        end
    end

    // ****
    // Sequence
    // ****
    initial begin
        repeat (6) @(negedge clock);
        rstn = 1'b1;
        repeat (4) @(negedge clock);
        reg_read(RADIO_NEXT_STATE_CONFIG_ADDR, rx);
        check_val("next state reset", 8'h30, rx);
        reg_read(RADIO_CALIBRATION_CONFIG_ADDR, rx);
        check_val("calibration reset", 8'h04, rx);
        reg_write(6'h20, 8'hff);
        reg_read(6'h20, rx);
        check_val("unmapped read", UNMAPPED_READ, rx);
        reg_write(RADIO_NEXT_STATE_CONFIG_ADDR, 8'hff);
        reg_read(RADIO_NEXT_STATE_CONFIG_ADDR, rx);
        check_val("next state readback", 8'h3f, rx);
        check_val("after receive port", 8'h03, {6'h00, after_receive_state});
        reg_write(RADIO_CALIBRATION_CONFIG_ADDR, 8'hff);
        reg_read(RADIO_CALIBRATION_CONFIG_ADDR, rx);
        check_val("calibration readback", 8'h3c, rx);
        $display("test registers done");
        for (int m = 0; m < 4; m++) begin
            reg_write(RADIO_NEXT_STATE_CONFIG_ADDR, {2'b00, m[1:0], 4'h0});
            for (int c = 0; c < 4; c++) begin
                {receiving_packet, signal_below_threshold} = c[1:0];
                repeat (3) @(negedge clock);
                exp = (m == 0) || (m == 1 && c[0]) || (m == 2 && !c[1]) || (m == 3 && c == 1);
                check_val("clear channel", {7'h00, exp}, {7'h00, clear_channel_assessment});
            end
        end
        $display("test clear channel done");
        for (int m = 0; m < 4; m++) begin
            reg_write(RADIO_NEXT_STATE_CONFIG_ADDR, {6'h00, m[1:0]});
            check_val("after transmit port", {6'h00, m[1:0]}, {6'h00, after_transmit_state});
            restart_seen = 0;
            pulse(0);
            check_count("preamble restart", m == 2, m == 2, restart_seen);
        end
        $display("test after transmit done");
        for (int m = 0; m < 4; m++) begin
            reg_write(RADIO_CALIBRATION_CONFIG_ADDR, {2'b00, m[1:0], 4'h4});
            cal_seen = 0;
            pulse(1);
            repeat (9) pulse(2);
            exp_n = (m == 1) ? 1 : (m == 2) ? 9 : (m == 3) ? 2 : 0;
            check_count("auto calibration", exp_n, exp_n, cal_seen);
        end
        // Ninth return already counted, three more reach the next fourth
        repeat (3) pulse(2);
        check_count("fourth return", 3, 3, cal_seen);
        reg_write(RADIO_CALIBRATION_CONFIG_ADDR, 8'h04);
        cal_seen = 0;
        strobe();
        pulse(2);
        check_count("calibrate strobe", 1, 1, cal_seen);
        $display("test calibration done");
        for (int p = 0; p < 4; p++) begin
            reg_write(RADIO_CALIBRATION_CONFIG_ADDR, {4'h0, p[1:0], 2'b00});
            xosc_stable = 1'b0;
            repeat (4) @(negedge clock);
            check_val("chip ready unstable", 8'h01, {7'h00, chip_ready_low});
            xosc_stable = 1'b1;
            wait_n = 0;
            while (chip_ready_low !== 1'b0 && wait_n < 20000) begin
                @(negedge clock);
                wait_n++;
            end
            exp_n = 64 << (p == 0 ? 0 : 2 * p + 2);
            check_count("power on wait", exp_n - 2, exp_n + 4, wait_n);
        end
        $display("test power on done");
        end_sim();
    end
endmodule // tb_radio_state_policy_config
